// File: hdl/clock_port_regs_pkg.sv
package clock_port_regs_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PLL_CONTROL_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OSC_CONTROL_STATUS = 8'h05;
  localparam logic [7:0] ADDR_CONTROL_PORT_MODE  = 8'h06;

  // Field positions, pll_control_status
  localparam int POS_PLL_LOCK_FLAG = 4;
  localparam int POS_PLL_ENABLE    = 0;
  // Field positions, oscillator_control_status
  localparam int POS_OSC_SELECTED  = 5;
  localparam int POS_OSC_POWERDOWN = 4;
  localparam int POS_OSC_AUTO_DIS  = 0;
  // Field positions, control_port_mode
  localparam int POS_LEGACY_INC    = 4;
  localparam int POS_PAGE_WRAP_DIS = 3;
  localparam int POS_BOOK0_DELAY   = 2;
  localparam int POS_MISO_FUNC     = 1;

  // Reset values
  localparam logic RST_PLL_ENABLE      = 1'b1;
  localparam logic RST_OSC_AUTO_DIS    = 1'b1;
  localparam logic RST_LEGACY_INC      = 1'b0;
  localparam logic RST_PAGE_WRAP_DIS   = 1'b0;
  localparam logic RST_BOOK0_DELAY     = 1'b0;
  localparam logic RST_LOCK_FLAG       = 1'b1;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // Address pointer constants
  localparam logic [6:0] PAGE_LAST_ADDR    = 7'h7F;
  localparam logic [6:0] PAGE_FIRST_ADDR   = 7'h00;
  localparam logic [6:0] NEXT_PAGE_ADDR    = 7'h08;
  localparam logic [6:0] ADDR_STEP         = 7'h01;
  localparam logic [7:0] PAGE_STEP         = 8'h01;
  localparam logic [7:0] BOOK_ZERO         = 8'h00;
  localparam int         INC_FLAG_POS      = 7;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;
  localparam int SYNC_COUNT  = 3;

  // MISO pin function codes
  typedef enum logic [1:0] {
    MISO_SPI_DATA = 2'b00,
    MISO_GPIO     = 2'b01
  } miso_func_t;

  // Register access request from the control-port front end
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Address pointer command from the control-port front end
  typedef struct packed {
    logic       load;
    logic       advance;
    logic [7:0] addr_byte;
    logic [7:0] book;
    logic [7:0] page;
    logic       is_spi;
    logic       is_read;
  } ptr_cmd_t;

endpackage : clock_port_regs_pkg

// File: hdl/clock_status_and_port_mode_regs.sv
`timescale 1ns/100ps
// Contract
// - Bit 4 of register 0x04 reads 0 while the PLL is locked and 1 while it is not.
// - While the PLL is disabled the lock flag always reads not locked.
// - The PLL enable bit 0 resets to 1; at 0 the PLL is off and master clock comes from the pin.
// - Bit 5 of register 0x05 reads 1 while the internal oscillator is the master clock.
// - Bit 4 of register 0x05 reads 1 while the oscillator is auto powered down, else 0.
// - Auto-disable bit 0 of 0x05 resets to 1 and powers the oscillator down when unneeded.
// - With the legacy increment bit 4 of 0x06 at 0 the I2C address always auto-increments.
// - With the legacy bit at 1 the I2C address increments only if the address byte MSB is set.
// - In non-zero books with page wrap bit 3 at 0 a page overrun continues at address 8 of next page.
// - With page wrap bit 3 at 1 a page overrun returns to address 0 of the same page.
// - SPI reads of non-zero books get one frame of delay between address and data.
// - Frame delay bit 2 resets to 0; at 1 book-zero SPI reads get the same one-frame delay.
// - MISO function bit 1 selects SPI data-out for code 00 and general IO three for code 01.
module clock_status_and_port_mode_regs
  import clock_port_regs_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire reg_req_t   i_req,
  input  wire ptr_cmd_t   i_ptr,
  input  wire logic       i_pll_locked,
  input  wire logic       i_osc_selected,
  input  wire logic       i_osc_needed,
  input  wire logic       i_spi_sdo_data,
  input  wire logic       i_spi_sdo_en,
  input  wire logic       i_general_io_three_out,
  input  wire logic       i_general_io_three_oe,
  input  wire logic       i_miso_pin_in,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  output logic            o_pll_enable,
  output logic            o_mclk_from_pin,
  output logic            o_osc_power_down,
  output logic [6:0]      o_reg_addr,
  output logic [7:0]      o_page,
  output logic [7:0]      o_book,
  output logic            o_incrementing,
  output logic            o_read_delay,
  output logic            o_miso_out,
  output logic            o_miso_oe,
  output logic            o_general_io_three_in
);

  // Pin inputs to synchronise: lock, oscillator select, MISO pin level
  localparam int N_SYNC = 3;
  logic [N_SYNC-1:0] raw_in;
  logic [N_SYNC-1:0] filt;
  assign raw_in = {i_miso_pin_in, i_osc_selected, i_pll_locked};

  // Three-stage synchroniser per input, change taken when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
      logic [SYNC_STAGES-1:0] stage;
      logic                   held;
      logic                   next_held;
      always_comb begin
        next_held = held;
        if (stage[1] == stage[2]) begin
          next_held = stage[2];
        end
      end
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          stage <= '0;
          held  <= 1'b0;
        end else begin
          stage <= {stage[SYNC_STAGES-2:0], raw_in[g]};
          held  <= next_held;
        end
      end
      assign filt[g] = held;
    end
  endgenerate

  logic lock_sync;
  logic osc_sel_sync;
  logic miso_pin_sync;
  assign lock_sync     = filt[0];
  assign osc_sel_sync  = filt[1];
  assign miso_pin_sync = filt[2];

  // Control bits written by software
  logic       pll_enable;
  logic       osc_auto_disable;
  logic       legacy_increment_mode;
  logic       page_wrap_disable;
  logic       book_zero_read_delay;
  miso_func_t miso_function_select;
  logic       next_pll_enable;
  logic       next_osc_auto_disable;
  logic       next_legacy_increment_mode;
  logic       next_page_wrap_disable;
  logic       next_book_zero_read_delay;
  miso_func_t next_miso_function_select;

  // Live status flags
  logic pll_lock_flag;
  logic osc_selected_flag;
  logic osc_powered_down_flag;
  logic next_pll_lock_flag;
  logic next_osc_selected_flag;
  logic next_osc_powered_down_flag;

  // Read answer
  logic [7:0] rdata;
  logic       rvalid;
  logic [7:0] next_rdata;
  logic       next_rvalid;

  // Register writes and status tracking
  always_comb begin
    next_pll_enable            = pll_enable;
    next_osc_auto_disable      = osc_auto_disable;
    next_legacy_increment_mode = legacy_increment_mode;
    next_page_wrap_disable     = page_wrap_disable;
    next_book_zero_read_delay  = book_zero_read_delay;
    next_miso_function_select  = miso_function_select;
    if (i_req.valid && i_req.write) begin
      case (i_req.addr)
        ADDR_PLL_CONTROL_STATUS: begin
          next_pll_enable = i_req.wdata[POS_PLL_ENABLE];
        end
        ADDR_OSC_CONTROL_STATUS: begin
          next_osc_auto_disable = i_req.wdata[POS_OSC_AUTO_DIS];
        end
        ADDR_CONTROL_PORT_MODE: begin
          next_legacy_increment_mode = i_req.wdata[POS_LEGACY_INC];
          next_page_wrap_disable     = i_req.wdata[POS_PAGE_WRAP_DIS];
          next_book_zero_read_delay  = i_req.wdata[POS_BOOK0_DELAY];
          next_miso_function_select  = i_req.wdata[POS_MISO_FUNC] ? MISO_GPIO
                                                                  : MISO_SPI_DATA;
        end
        default: begin
          next_pll_enable = pll_enable;
        end
      endcase
    end
    next_pll_lock_flag         = ~(pll_enable & lock_sync);
    next_osc_selected_flag     = osc_sel_sync;
    next_osc_powered_down_flag = osc_auto_disable & ~i_osc_needed & ~osc_sel_sync;
  end

  // Read mux, reserved bits read zero, unmapped offsets read zero
  always_comb begin
    next_rvalid = i_req.valid & ~i_req.write;
    next_rdata  = rdata;
    if (i_req.valid && !i_req.write) begin
      next_rdata = RST_READ_DATA;
      case (i_req.addr)
        ADDR_PLL_CONTROL_STATUS: begin
          next_rdata[POS_PLL_LOCK_FLAG] = pll_lock_flag;
          next_rdata[POS_PLL_ENABLE]    = pll_enable;
        end
        ADDR_OSC_CONTROL_STATUS: begin
          next_rdata[POS_OSC_SELECTED]  = osc_selected_flag;
          next_rdata[POS_OSC_POWERDOWN] = osc_powered_down_flag;
          next_rdata[POS_OSC_AUTO_DIS]  = osc_auto_disable;
        end
        ADDR_CONTROL_PORT_MODE: begin
          next_rdata[POS_LEGACY_INC]    = legacy_increment_mode;
          next_rdata[POS_PAGE_WRAP_DIS] = page_wrap_disable;
          next_rdata[POS_BOOK0_DELAY]   = book_zero_read_delay;
          next_rdata[POS_MISO_FUNC]     = miso_function_select[0];
        end
        default: begin
          next_rdata = RST_READ_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pll_enable            <= RST_PLL_ENABLE;
      osc_auto_disable      <= RST_OSC_AUTO_DIS;
      legacy_increment_mode <= RST_LEGACY_INC;
      page_wrap_disable     <= RST_PAGE_WRAP_DIS;
      book_zero_read_delay  <= RST_BOOK0_DELAY;
      miso_function_select  <= MISO_SPI_DATA;
      pll_lock_flag         <= RST_LOCK_FLAG;
      osc_selected_flag     <= 1'b0;
      osc_powered_down_flag <= 1'b0;
      rdata                 <= RST_READ_DATA;
      rvalid                <= 1'b0;
    end else begin
      pll_enable            <= next_pll_enable;
      osc_auto_disable      <= next_osc_auto_disable;
      legacy_increment_mode <= next_legacy_increment_mode;
      page_wrap_disable     <= next_page_wrap_disable;
      book_zero_read_delay  <= next_book_zero_read_delay;
      miso_function_select  <= next_miso_function_select;
      pll_lock_flag         <= next_pll_lock_flag;
      osc_selected_flag     <= next_osc_selected_flag;
      osc_powered_down_flag <= next_osc_powered_down_flag;
      rdata                 <= next_rdata;
      rvalid                <= next_rvalid;
    end
  end

  // Address pointer state
  logic [6:0] reg_addr;
  logic [7:0] page;
  logic [7:0] book;
  logic       incrementing;
  logic       read_delay;
  logic [6:0] next_reg_addr;
  logic [7:0] next_page;
  logic [7:0] next_book;
  logic       next_incrementing;
  logic       next_read_delay;

  // Pointer load and advance
  always_comb begin
    next_reg_addr     = reg_addr;
    next_page         = page;
    next_book         = book;
    next_incrementing = incrementing;
    next_read_delay   = read_delay;
    if (i_ptr.load) begin
      next_reg_addr     = i_ptr.addr_byte[6:0];
      next_page         = i_ptr.page;
      next_book         = i_ptr.book;
      // Legacy mode on I2C decides per transfer from the address MSB
      next_incrementing = i_ptr.is_spi | ~legacy_increment_mode
                          | i_ptr.addr_byte[INC_FLAG_POS];
      next_read_delay   = i_ptr.is_spi & i_ptr.is_read
                          & ((i_ptr.book != BOOK_ZERO) | book_zero_read_delay);
    end else if (i_ptr.advance && incrementing) begin
      if (reg_addr == PAGE_LAST_ADDR) begin
        if ((book != BOOK_ZERO) && !page_wrap_disable) begin
          next_page     = page + PAGE_STEP;
          next_reg_addr = NEXT_PAGE_ADDR;
        end else begin
          next_reg_addr = PAGE_FIRST_ADDR;
        end
      end else begin
        next_reg_addr = reg_addr + ADDR_STEP;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      reg_addr     <= PAGE_FIRST_ADDR;
      page         <= BOOK_ZERO;
      book         <= BOOK_ZERO;
      incrementing <= 1'b1;
      read_delay   <= 1'b0;
    end else begin
      reg_addr     <= next_reg_addr;
      page         <= next_page;
      book         <= next_book;
      incrementing <= next_incrementing;
      read_delay   <= next_read_delay;
    end
  end

  // MISO pin function and clock routing
  logic next_miso_out;
  logic next_miso_oe;
  always_comb begin
    case (miso_function_select)
      MISO_SPI_DATA: begin
        next_miso_out = i_spi_sdo_data;
        next_miso_oe  = i_spi_sdo_en;
      end
      MISO_GPIO: begin
        next_miso_out = i_general_io_three_out;
        next_miso_oe  = i_general_io_three_oe;
      end
      default: begin
        next_miso_out = 1'b0;
        next_miso_oe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_miso_out       <= 1'b0;
      o_miso_oe        <= 1'b0;
      o_general_io_three_in       <= 1'b0;
      o_pll_enable     <= RST_PLL_ENABLE;
      o_mclk_from_pin  <= ~RST_PLL_ENABLE;
      o_osc_power_down <= 1'b0;
    end else begin
      o_miso_out       <= next_miso_out;
      o_miso_oe        <= next_miso_oe;
      o_general_io_three_in       <= miso_pin_sync;
      o_pll_enable     <= pll_enable;
      o_mclk_from_pin  <= ~pll_enable;
      o_osc_power_down <= next_osc_powered_down_flag;
    end
  end

  // Registered outputs
  assign o_rdata        = rdata;
  assign o_rvalid       = rvalid;
  assign o_reg_addr     = reg_addr;
  assign o_page         = page;
  assign o_book         = book;
  assign o_incrementing = incrementing;
  assign o_read_delay   = read_delay;

endmodule : clock_status_and_port_mode_regs

// File: verif/clock_regs_checker_props.sv
`timescale 1ns/100ps
module clock_regs_checker
  import clock_port_regs_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire reg_req_t   i_req,
  input  wire ptr_cmd_t   i_ptr,
  input  wire logic       i_osc_needed,
  input  wire logic       o_rvalid,
  input  wire logic       o_pll_enable,
  input  wire logic       o_mclk_from_pin,
  input  wire logic       o_osc_power_down,
  input  wire logic [6:0] o_reg_addr,
  input  wire logic [7:0] o_page,
  input  wire logic [7:0] o_book,
  input  wire logic       o_incrementing,
  input  wire logic       o_read_delay
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Advance that the pointer must honour
  logic adv;
  assign adv = i_ptr.advance & ~i_ptr.load & o_incrementing;
  a_read_answer: assert property (i_req.valid && !i_req.write |=> o_rvalid)
    else $error("read got no answer");
  a_clock_source: assert property (o_mclk_from_pin == !o_pll_enable)
    else $error("master clock source disagrees with pll enable");
  a_enable_write: assert property (i_req.valid && i_req.write && i_req.addr == ADDR_PLL_CONTROL_STATUS
    |-> ##2 o_pll_enable == $past(i_req.wdata[POS_PLL_ENABLE], 2))
    else $error("pll enable write lost");
  a_osc_kept_on: assert property ($past(i_osc_needed) |-> !o_osc_power_down)
    else $error("oscillator down while needed");
  a_hold_pointer: assert property (i_ptr.advance && !i_ptr.load && !o_incrementing
    |=> $stable(o_reg_addr) && $stable(o_page))
    else $error("pointer moved without increment");
  a_step_addr: assert property (adv && o_reg_addr != PAGE_LAST_ADDR
    |=> o_reg_addr == $past(o_reg_addr) + ADDR_STEP)
    else $error("address step wrong");
  a_page_end: assert property (adv && o_reg_addr == PAGE_LAST_ADDR
    |=> (o_reg_addr == NEXT_PAGE_ADDR && o_page == $past(o_page) + PAGE_STEP)
    || (o_reg_addr == PAGE_FIRST_ADDR && $stable(o_page)))
    else $error("page end handling wrong");
  a_load_takes: assert property (i_ptr.load |=> o_reg_addr == $past(i_ptr.addr_byte[6:0])
    && o_book == $past(i_ptr.book))
    else $error("pointer load wrong");
  a_spi_incr: assert property (i_ptr.load && (i_ptr.is_spi || i_ptr.addr_byte[INC_FLAG_POS])
    |=> o_incrementing)
    else $error("increment not enabled");
  a_delay_book: assert property (i_ptr.load && i_ptr.is_spi && i_ptr.is_read
    && i_ptr.book != BOOK_ZERO |=> o_read_delay)
    else $error("missing read delay");
endmodule : clock_regs_checker
bind clock_status_and_port_mode_regs clock_regs_checker clock_regs_checker_inst (
  .i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .i_ptr(i_ptr), .i_osc_needed(i_osc_needed),
  .o_rvalid(o_rvalid), .o_pll_enable(o_pll_enable), .o_mclk_from_pin(o_mclk_from_pin),
  .o_osc_power_down(o_osc_power_down), .o_reg_addr(o_reg_addr), .o_page(o_page),
  .o_book(o_book), .o_incrementing(o_incrementing), .o_read_delay(o_read_delay));

// File: verif/clock_pin_model.sv
`timescale 1ns/100ps
module clock_pin_model #(
  parameter int LOCK_CYCLES = 4
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_pll_enable,
  input  wire logic i_stuck_lock,
  input  wire logic i_miso_out,
  input  wire logic i_miso_oe,
  output logic      o_pll_locked,
  output logic      o_miso_pin
);
  logic [3:0] lock_count;
  // PLL gains lock a while after enable, loses it at once when off unless i_stuck_lock holds it locked
  always_ff @(posedge i_clock) begin
    if (i_rst || !i_pll_enable) begin
      lock_count <= 4'h0;
    end else if (lock_count != LOCK_CYCLES[3:0]) begin
      lock_count <= lock_count + 4'h1;
    end
  end
  assign o_pll_locked = i_stuck_lock | (i_pll_enable & (lock_count == LOCK_CYCLES[3:0]));
  // Pulled up when undriven; pin level feeds back to the MISO pin input in io mode
  assign o_miso_pin = i_miso_oe ? i_miso_out : 1'b1;
endmodule : clock_pin_model

// File: verif/clock_status_and_port_mode_regs_tb.sv
`timescale 1ns/100ps
module clock_status_and_port_mode_regs_tb
  import clock_port_regs_pkg::*;
;
  logic       i_clock, i_rst, i_osc_selected, i_osc_needed, i_spi_sdo_data, i_spi_sdo_en;
  logic       i_general_io_three_out, i_general_io_three_oe, pll_locked, miso_pin, stuck;
  reg_req_t   i_req;
  ptr_cmd_t   i_ptr;
  logic [7:0] o_rdata, o_page, o_book;
  logic [6:0] o_reg_addr;
  logic       o_rvalid, o_pll_enable, o_mclk_from_pin, o_osc_power_down, o_incrementing;
  logic       o_read_delay, o_miso_out, o_miso_oe, o_general_io_three_in;
  int         fail_count, check_count;
  clock_status_and_port_mode_regs clock_status_and_port_mode_regs_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .i_ptr(i_ptr), .i_pll_locked(pll_locked),
    .i_osc_selected(i_osc_selected), .i_osc_needed(i_osc_needed),
    .i_spi_sdo_data(i_spi_sdo_data), .i_spi_sdo_en(i_spi_sdo_en), .i_general_io_three_out(i_general_io_three_out),
    .i_general_io_three_oe(i_general_io_three_oe), .i_miso_pin_in(miso_pin), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_pll_enable(o_pll_enable), .o_mclk_from_pin(o_mclk_from_pin),
    .o_osc_power_down(o_osc_power_down), .o_reg_addr(o_reg_addr), .o_page(o_page),
    .o_book(o_book), .o_incrementing(o_incrementing), .o_read_delay(o_read_delay),
    .o_miso_out(o_miso_out), .o_miso_oe(o_miso_oe), .o_general_io_three_in(o_general_io_three_in));
  clock_pin_model clock_pin_model_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_pll_enable(o_pll_enable), .i_stuck_lock(stuck),
    .i_miso_out(o_miso_out), .i_miso_oe(o_miso_oe), .o_pll_locked(pll_locked),
    .o_miso_pin(miso_pin));
  // Verdict and end of run
  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Compare one result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock) i_req <= '{1'b1, 1'b1, a, d};
    @(negedge i_clock) i_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clock) i_req <= '{1'b1, 1'b0, a, 8'h00};
    @(negedge i_clock) i_req <= '0;
    chk(o_rdata, e);
    chk({7'h00, o_rvalid}, 8'h01);
  endtask : rd
  // Pointer command: load or advance
  task automatic ptr(input logic ld, input logic [7:0] ab, input logic [7:0] bk,
                     input logic [7:0] pg, input logic spi, input logic rdx);
    @(negedge i_clock) i_ptr <= '{ld, ~ld, ab, bk, pg, spi, rdx};
    @(negedge i_clock) i_ptr <= '0;
  endtask : ptr
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    fail_count++;
    test_done();
  end
  // Main sequence
  initial begin
    {i_rst, i_osc_selected, i_osc_needed, i_spi_sdo_data, i_spi_sdo_en} = 5'h10;
    {i_general_io_three_out, i_general_io_three_oe, stuck} = 3'h0;
    i_req = '0;
    i_ptr = '0;
    fail_count = 0;
    check_count = 0;
    idle(3);
    i_rst <= 1'b0;
    rd(ADDR_CONTROL_PORT_MODE, 8'h00);
    rd(ADDR_OSC_CONTROL_STATUS, 8'h11);
    chk({7'h00, o_osc_power_down}, 8'h01);
    rd(ADDR_PLL_CONTROL_STATUS, 8'h11);
    idle(12);
    rd(ADDR_PLL_CONTROL_STATUS, 8'h01);
    i_osc_needed <= 1'b1;
    idle(6);
    rd(ADDR_OSC_CONTROL_STATUS, 8'h01);
    chk({7'h00, o_osc_power_down}, 8'h00);
    i_osc_selected <= 1'b1;
    idle(6);
    rd(ADDR_OSC_CONTROL_STATUS, 8'h21);
    {i_osc_selected, i_osc_needed} <= 2'b00;
    wr(ADDR_OSC_CONTROL_STATUS, 8'h30);
    idle(6);
    rd(ADDR_OSC_CONTROL_STATUS, 8'h00);
    wr(ADDR_OSC_CONTROL_STATUS, 8'h01);
    stuck <= 1'b1;
    wr(ADDR_PLL_CONTROL_STATUS, 8'h00);
    idle(6);
    rd(ADDR_PLL_CONTROL_STATUS, 8'h10);
    chk({6'h00, o_pll_enable, o_mclk_from_pin}, 8'h01);
    wr(ADDR_PLL_CONTROL_STATUS, 8'h11);
    stuck <= 1'b0;
    idle(12);
    rd(ADDR_PLL_CONTROL_STATUS, 8'h01);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(ADDR_CONTROL_PORT_MODE, 8'h1F);
    rd(ADDR_CONTROL_PORT_MODE, 8'h1E);
    ptr(1'b1, 8'h05, 8'h00, 8'h00, 1'b0, 1'b0);
    ptr(1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk({o_incrementing, o_reg_addr}, 8'h05);
    ptr(1'b1, 8'h85, 8'h00, 8'h00, 1'b0, 1'b0);
    ptr(1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk({1'b0, o_reg_addr}, 8'h06);
    ptr(1'b1, 8'hFF, 8'h01, 8'h02, 1'b0, 1'b0);
    ptr(1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk({o_page[0], o_reg_addr}, 8'h00);
    ptr(1'b1, 8'h05, 8'h00, 8'h00, 1'b1, 1'b1);
    chk({7'h00, o_read_delay}, 8'h01);
    wr(ADDR_CONTROL_PORT_MODE, 8'h00);
    ptr(1'b1, 8'hFF, 8'h01, 8'h02, 1'b0, 1'b0);
    ptr(1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk({o_page[0], o_reg_addr}, 8'h88);
    ptr(1'b1, 8'h05, 8'h00, 8'h00, 1'b0, 1'b0);
    chk({7'h00, o_incrementing}, 8'h01);
    ptr(1'b1, 8'h05, 8'h00, 8'h00, 1'b1, 1'b1);
    chk({7'h00, o_read_delay}, 8'h00);
    ptr(1'b1, 8'h05, 8'h01, 8'h00, 1'b1, 1'b1);
    chk({o_book[0], 6'h00, o_read_delay}, 8'h81);
    {i_spi_sdo_data, i_spi_sdo_en} <= 2'b11;
    idle(2);
    chk({6'h00, o_miso_out, o_miso_oe}, 8'h03);
    wr(ADDR_CONTROL_PORT_MODE, 8'h02);
    i_general_io_three_oe <= 1'b1;
    idle(6);
    chk({5'h00, o_miso_out, o_miso_oe, o_general_io_three_in}, 8'h02);
    i_general_io_three_oe <= 1'b0;
    idle(6);
    chk({5'h00, o_miso_out, o_miso_oe, o_general_io_three_in}, 8'h01);
    test_done();
  end
endmodule : clock_status_and_port_mode_regs_tb
